/* File: design/fwl_top.sv */
// Contract
// - write enable redirects external moves to flash
// - write enable cleared only by software
// - keys first then second before operation
// - key spacing does not matter
// - wrong or misordered key locks until reset
// - operation before unlock locks until reset
// - lock rearms after each external operation; debug operations leave it as it is
// - supply monitor off gives flash error reset; the debug path skips this check and runs its operation
// - write clears bits only, erase sets 0xFF
// - operations timed by hardware
// - core stalled during operation
// - write plus erase enable erases page
// - interrupts held pending during operation
// - debug port also programs flash
//
// The register offsets and register access over APB are this design's own decisions.
module fwl_top
  import fwl_pkg::*;
#(
  parameter int WRITE_CYCLES = fwl_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = fwl_pkg::ERASE_CYC
) (
  input  wire logic                          I_CLK,
  input  wire logic                          I_NRST,
  input  wire logic                          I_PSEL,
  input  wire logic                          I_PENABLE,
  input  wire logic                          I_PWRITE,
  input  wire logic [7:0]                    I_PADDR,
  input  wire logic [31:0]                   I_PWDATA,
  output logic      [31:0]                   O_PRDATA,
  output logic                               O_PREADY,
  output logic                               O_PSLVERR,
  input  wire logic                          I_XWR,
  input  wire logic [fwl_pkg::ADDR_W-1:0]    I_XADDR,
  input  wire logic [7:0]                    I_XDATA,
  input  wire logic                          I_VMON_EN,
  input  wire logic                          I_VMON_RST_EN,
  input  wire logic                          I_DBG_REQ,
  input  wire logic [fwl_pkg::DBG_CMD_W-1:0] I_DBG_CMD,
  input  wire logic [fwl_pkg::ADDR_W-1:0]    I_DBG_ADDR,
  input  wire logic [7:0]                    I_DBG_DATA,
  output logic                               O_DBG_DONE,
  output logic                               O_STALL,
  output logic                               O_IRQ_HOLD,
  output logic                               O_FERR_RST,
  output logic                               O_XWR_RAM,
  output logic                               O_IRQ
);
  import fwl_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic                we;
    logic                ee;
    fwl_lock_t           lock;
    fwl_op_t             op;
    logic [CNT_W-1:0]    cnt;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          data;
    logic                dbg;
    logic                dbg_arm;
    logic                dbg_done;
    logic                ferr;
    logic [EV_W-1:0]     irq;
    logic [EV_W-1:0]     mask;
    logic [31:0]         prdata;
  } fwl_state_t;

  fwl_state_t r;
  fwl_state_t next_r;

  logic       vmon_en;
  logic       vmon_rst;
  logic       dbg_req;
  logic [7:0] rdata;
  logic       mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata;

  // supply monitor flags and debug request come from other domains
  fwl_sync u_sync_ven (
    .I_CLK  (I_CLK),
    .I_NRST (I_NRST),
    .i_d    (I_VMON_EN),
    .o_q    (vmon_en)
  );

  fwl_sync u_sync_vrs (
    .I_CLK  (I_CLK),
    .I_NRST (I_NRST),
    .i_d    (I_VMON_RST_EN),
    .o_q    (vmon_rst)
  );

  // debug command, address and data are held stable while the request stands
  fwl_sync u_sync_dbg (
    .I_CLK  (I_CLK),
    .I_NRST (I_NRST),
    .i_d    (I_DBG_REQ),
    .o_q    (dbg_req)
  );

  fwl_mem #(.AW(ADDR_W)) u_mem (
    .I_CLK   (I_CLK),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (rdata)
  );

  // ==========================================================================
  // apb decode, zero wait states
  logic apb_wr;
  logic apb_rd;
  logic busy;
  logic sw_req;
  logic [EV_W-1:0] ev;
  logic page_last;

  assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE;
  assign apb_rd    = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign busy      = (r.op != OP_IDLE);
  assign sw_req    = I_XWR && r.we && !busy;
  assign page_last = (r.cnt[PAGE_W-1:0] == {PAGE_W{1'b1}});

  always_comb begin
    next_r    = r;
    ev        = '0;
    mem_we    = 1'b0;
    mem_addr  = r.addr;
    mem_wdata = r.data & rdata;
    next_r.dbg_done = 1'b0;

    // a held debug request starts one operation only; the synchronised
    // request lags the done pulse, so it must be seen low before rearming
    if (!dbg_req) begin
      next_r.dbg_arm = 1'b1;
    end

    // ------------------------------------------------------------------------
    // register writes
    if (apb_wr) begin
      unique case (I_PADDR)
        REG_PSC: begin
          next_r.we = I_PWDATA[PSC_WE];
          next_r.ee = I_PWDATA[PSC_EE];
        end
        REG_KEY: begin
          unique case (r.lock)
            LK_WAIT1: next_r.lock = (I_PWDATA[7:0] == KEY_FIRST) ? LK_WAIT2 : LK_DEAD;
            LK_WAIT2: next_r.lock = (I_PWDATA[7:0] == KEY_SECOND) ? LK_OPEN : LK_DEAD;
            LK_OPEN:  next_r.lock = LK_DEAD;
            LK_DEAD:  next_r.lock = LK_DEAD;
          endcase
          if (next_r.lock == LK_DEAD && r.lock != LK_DEAD) begin
            ev[EV_LOCK] = 1'b1;
          end
        end
        REG_MASK: next_r.mask = I_PWDATA[EV_W-1:0];
        default: ;
      endcase
    end

    // ------------------------------------------------------------------------
    // start of an operation
    if (r.op == OP_IDLE) begin
      if (sw_req) begin
        if (!vmon_en || !vmon_rst) begin
          next_r.ferr = 1'b1;
          ev[EV_FERR] = 1'b1;
        end else if (r.lock != LK_OPEN) begin
          if (r.lock != LK_DEAD) begin
            ev[EV_LOCK] = 1'b1;
          end
          next_r.lock = LK_DEAD;
        end else begin
          next_r.addr = I_XADDR;
          next_r.data = I_XDATA;
          next_r.dbg  = 1'b0;
          next_r.cnt  = '0;
          next_r.op   = r.ee ? OP_ERASE : OP_WRITE;
        end
      end else if (dbg_req && r.dbg_arm) begin
        // debug path bypasses the key lock, sole route for blank parts
        next_r.dbg_arm = 1'b0;
        next_r.addr = I_DBG_ADDR;
        next_r.data = I_DBG_DATA;
        next_r.dbg  = 1'b1;
        next_r.cnt  = '0;
        next_r.op   = (I_DBG_CMD == DBG_ERASE) ? OP_ERASE : OP_WRITE;
      end
    end

    // ------------------------------------------------------------------------
    // timed operation; a write touches the array in its last cycle, an erase in its first 2**PAGE_W cycles
    unique case (r.op)
      OP_IDLE: ;
      OP_WRITE: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(WRITE_CYCLES - 1)) begin
          mem_we    = 1'b1;
          next_r.op = OP_DONE;
        end
      end
      OP_ERASE: begin
        next_r.cnt = r.cnt + 1'b1;
        mem_addr   = {r.addr[ADDR_W-1:PAGE_W], r.cnt[PAGE_W-1:0]};
        if (r.cnt < CNT_W'(2 ** PAGE_W)) begin
          mem_we    = 1'b1;
          mem_wdata = ERASED;
        end
        if (r.cnt == CNT_W'(ERASE_CYCLES - 1)) begin
          next_r.op = OP_DONE;
        end
      end
      OP_DONE: begin
        next_r.op = OP_IDLE;
        ev[EV_DONE] = 1'b1;
        next_r.dbg_done = r.dbg;
        if (!r.dbg && r.lock == LK_OPEN) begin
          next_r.lock = LK_WAIT1;
        end
      end
    endcase

    // ------------------------------------------------------------------------
    // sticky events: set beats write-one-to-clear
    if (apb_wr && I_PADDR == REG_IRQ) begin
      next_r.irq = r.irq & ~I_PWDATA[EV_W-1:0];
    end
    next_r.irq = next_r.irq | ev;

    // ------------------------------------------------------------------------
    if (apb_rd) begin
      unique case (I_PADDR)
        REG_PSC:    next_r.prdata = {30'h0, r.ee, r.we};
        REG_STATUS: next_r.prdata = {29'h0, r.lock == LK_DEAD, r.lock == LK_OPEN, busy};
        REG_IRQ:    next_r.prdata = {29'h0, r.irq};
        REG_MASK:   next_r.prdata = {29'h0, r.mask};
        default:    next_r.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      r <= '{we:       1'b0,
             ee:       1'b0,
             lock:     LK_WAIT1,
             op:       OP_IDLE,
             cnt:      '0,
             addr:     '0,
             data:     8'hFF,
             dbg:      1'b0,
             dbg_arm:  1'b0,
             dbg_done: 1'b0,
             ferr:     1'b0,
             irq:      '0,
             mask:     '0,
             prdata:   32'h0};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign O_PRDATA   = r.prdata;
  assign O_PREADY   = 1'b1;
  assign O_PSLVERR  = 1'b0;
  assign O_STALL    = busy;
  assign O_IRQ_HOLD = busy;
  assign O_FERR_RST = r.ferr;
  assign O_DBG_DONE = r.dbg_done;
  assign O_XWR_RAM  = I_XWR && !r.we;
  assign O_IRQ      = |(r.irq & r.mask);
endmodule

/* File: design/fwl_pkg.sv */
package fwl_pkg;
  // ==========================================================================
  // register map, byte addresses on the APB
  localparam logic [7:0] REG_PSC    = 8'h00;  // program_store_control
  localparam logic [7:0] REG_KEY    = 8'h04;  // flash_key_register
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ    = 8'h0C;  // sticky events, write one to clear
  localparam logic [7:0] REG_MASK   = 8'h10;
  // ==========================================================================
  // field positions
  localparam int PSC_WE  = 0;   // flash_write_enable
  localparam int PSC_EE  = 1;   // flash_erase_enable
  localparam int ST_BUSY = 0;
  localparam int ST_UNLK = 1;
  localparam int ST_DIS  = 2;
  localparam int EV_DONE = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_FERR = 2;
  localparam int EV_W    = 3;
  // ==========================================================================
  // key codes, erased value, timing
  localparam logic [7:0] KEY_FIRST  = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam int WRITE_TIME_US = 60;
  localparam int ERASE_TIME_US = 400;
  localparam int CLK_MHZ       = 10;
  localparam int WRITE_CYC     = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 13;
  localparam int ADDR_W        = 13;
  localparam int PAGE_W        = 9;
  localparam int DBG_CMD_W     = 2;
  localparam logic [1:0] DBG_WRITE = 2'h1;
  localparam logic [1:0] DBG_ERASE = 2'h2;
  // ==========================================================================
  typedef enum logic [3:0] {
    LK_WAIT1 = 4'b0001,
    LK_WAIT2 = 4'b0010,
    LK_OPEN  = 4'b0100,
    LK_DEAD  = 4'b1000
  } fwl_lock_t;
  typedef enum logic [3:0] {
    OP_IDLE  = 4'b0001,
    OP_WRITE = 4'b0010,
    OP_ERASE = 4'b0100,
    OP_DONE  = 4'b1000
  } fwl_op_t;
endpackage

/* File: design/fwl_mem.sv */
module fwl_mem #(
  parameter int AW = 13
) (
  input  wire logic          I_CLK,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  // ==========================================================================
  // flash array model: plain storage, read data registered
  logic [7:0] mem [2**AW];
  always_ff @(posedge I_CLK) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

/* File: design/fwl_sync.sv */
module fwl_sync (
  input  wire logic I_CLK,
  input  wire logic I_NRST,
  input  wire logic i_d,
  output logic      o_q
);
  // ==========================================================================
  logic meta;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      meta <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

/* File: verification/fwl_props.sv */
module fwl_props #(
  parameter int WRITE_CYCLES = fwl_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = fwl_pkg::ERASE_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic        I_XWR,
  input  wire logic        I_DBG_REQ,
  input  wire logic [31:0] O_PRDATA,
  input  wire logic        O_STALL,
  input  wire logic        O_IRQ_HOLD,
  input  wire logic        O_FERR_RST,
  input  wire logic        O_XWR_RAM
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] len;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // ==========================================================================
  // stall width, cleared while idle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST)
      len <= 16'h0;
    else
      len <= O_STALL ? len + 16'h1 : 16'h0;
  end
  // ==========================================================================
  property p_hold; O_IRQ_HOLD == O_STALL; endproperty
  a_hold: assert property (p_hold) else $error("irq hold differs from stall");
  property p_ram; O_XWR_RAM |-> I_XWR && !O_STALL; endproperty
  a_ram: assert property (p_ram) else $error("ram write without strobe");
  property p_len; $fell(O_STALL) |-> len == WRITE_CYCLES + 1 || len == ERASE_CYCLES + 1;
  endproperty
  a_len: assert property (p_len) else $error("stall width wrong");
  property p_max; O_STALL |-> len <= ERASE_CYCLES; endproperty
  a_max: assert property (p_max) else $error("stall never ends");
  property p_cause; $rose(O_STALL) |-> $past(I_XWR) || $past(I_DBG_REQ); endproperty
  a_cause: assert property (p_cause) else $error("stall without request");
  property p_ferr; O_FERR_RST |=> O_FERR_RST; endproperty
  a_ferr: assert property (p_ferr) else $error("flash error dropped");
  property p_ferr_nop; $rose(O_FERR_RST) |-> !O_STALL [*3]; endproperty
  a_ferr_nop: assert property (p_ferr_nop) else $error("operation ran on error");
  property p_rd; !(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  c_write: cover property ($fell(O_STALL) && len == WRITE_CYCLES + 1);
  c_erase: cover property ($fell(O_STALL) && len == ERASE_CYCLES + 1);
  c_ferr: cover property ($rose(O_FERR_RST));
endmodule

bind fwl_top fwl_props #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)
) fwl_props_inst (
  .I_CLK(I_CLK),
  .I_NRST(I_NRST),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE),
  .I_XWR(I_XWR),
  .I_DBG_REQ(I_DBG_REQ),
  .O_PRDATA(O_PRDATA),
  .O_STALL(O_STALL),
  .O_IRQ_HOLD(O_IRQ_HOLD),
  .O_FERR_RST(O_FERR_RST),
  .O_XWR_RAM(O_XWR_RAM)
);

/* File: verification/fwl_core_model.sv */
module fwl_core_model
  import fwl_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_go,
  input  wire logic                     i_stall,
  input  wire logic [fwl_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]               i_data,
  output logic                          o_xwr,
  output logic      [fwl_pkg::ADDR_W-1:0] o_addr,
  output logic      [7:0]               o_data,
  output int                            o_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // operands inverted on each idle cycle, so stale values reappear only on every other cycle
  // no interrupt entry: interrupts stay off around write enable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_xwr <= 1'b0;
      o_addr <= '0;
      o_data <= 8'h00;
      o_cnt <= 0;
    end else begin
      o_xwr <= i_go && !i_stall;
      o_addr <= i_go ? i_addr : ~o_addr;
      o_data <= i_go ? i_data : ~o_data;
      if (i_go)
        o_cnt <= 0;
      else if (i_stall)
        o_cnt <= o_cnt + 1;
    end
  end
endmodule

/* File: verification/tb_top.sv */
module tb_top;
  import fwl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 4;
  localparam int EC = 600;
  logic I_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic vm_rst = 1'b1;
  logic vm_en = 1'b1;
  logic dbg_req = 1'b0;
  logic [DBG_CMD_W-1:0] dbg_cmd = 2'h0;
  logic [ADDR_W-1:0] dbg_addr = '0;
  logic [7:0] dbg_data = 8'h00;
  logic dbg_done;
  logic slverr;
  logic go = 1'b0;
  logic ram_seen = 1'b0;
  logic [ADDR_W-1:0] xa;
  logic [7:0] xd;
  logic pready, stall, ferr, ram, irq, xwr;
  int cnt;
  int err_total = 0;
  int checks_done = 0;
  always #50 I_CLK = ~I_CLK;
  always @(negedge I_CLK) if (ram) ram_seen <= 1'b1;
  fwl_top #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) fwl_top_inst (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(slverr), .I_XWR(xwr), .I_XADDR(xa), .I_XDATA(xd), .I_VMON_EN(vm_en),
    .I_VMON_RST_EN(vm_rst), .I_DBG_REQ(dbg_req), .I_DBG_CMD(dbg_cmd), .I_DBG_ADDR(dbg_addr),
    .I_DBG_DATA(dbg_data), .O_DBG_DONE(dbg_done), .O_STALL(stall), .O_IRQ_HOLD(),
    .O_FERR_RST(ferr), .O_XWR_RAM(ram), .O_IRQ(irq));
  fwl_core_model fwl_core_model_inst (
    .i_clk(I_CLK), .i_nrst(I_NRST), .i_go(go), .i_stall(stall), .i_addr(13'h005),
    .i_data(8'h3C), .o_xwr(xwr), .o_addr(xa), .o_data(xd), .o_cnt(cnt));
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLK);
    pen <= 1'b1;
    do @(posedge I_CLK); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(prdata, exp, "register read");
    chk(slverr, 1'b0, "no slave error");
  endtask
  task automatic keys();
    apb(1'b1, REG_KEY, {24'h0, KEY_FIRST});
    repeat (7) @(posedge I_CLK);
    apb(1'b1, REG_KEY, {24'h0, KEY_SECOND});
  endtask
  // one external move; cnt is the stall width the core saw
  task automatic op(input int exp);
    @(posedge I_CLK);
    go <= 1'b1;
    @(posedge I_CLK);
    go <= 1'b0;
    repeat (3) @(negedge I_CLK);
    for (int n = 0; n < 5000 && stall; n++) @(negedge I_CLK);
    @(posedge I_CLK);
    chk(cnt, exp, "stall width");
  endtask
  task automatic reset();
    I_NRST <= 1'b0;
    repeat (10) @(posedge I_CLK);
    I_NRST <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  task automatic t_basic();
    rd(REG_PSC, 32'h0);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    op(0);
    chk(ram_seen, 1'b1, "ram redirect");
  endtask
  task automatic t_write_erase();
    apb(1'b1, REG_PSC, 32'h1);
    keys();
    rd(REG_STATUS, 32'h2);
    apb(1'b1, REG_MASK, 32'h1);
    op(WC + 1);
    rd(REG_STATUS, 32'h0);
    rd(REG_PSC, 32'h1);
    chk(irq, 1'b1, "done irq");
    apb(1'b1, REG_IRQ, 32'h1);
    @(negedge I_CLK);
    chk(irq, 1'b0, "irq cleared");
    op(0);
    apb(1'b1, REG_PSC, 32'h3);
    keys();
    op(0);
    reset();
    apb(1'b1, REG_PSC, 32'h3);
    keys();
    op(EC + 1);
  endtask
  task automatic t_dead(input logic [7:0] k);
    reset();
    apb(1'b1, REG_KEY, {24'h0, k});
    keys();
    apb(1'b1, REG_PSC, 32'h1);
    op(0);
    rd(REG_STATUS, 32'h4);
    rd(REG_IRQ, 32'h2);
  endtask
  // debug request held until done; the bench counts the stall itself
  task automatic t_debug(input logic [DBG_CMD_W-1:0] c, input int exp);
    int n = 0;
    @(posedge I_CLK);
    dbg_cmd <= c;
    dbg_addr <= 13'h020;
    dbg_data <= 8'h5A;
    dbg_req <= 1'b1;
    do begin
      @(posedge I_CLK);
      if (stall === 1'b1) n++;
    end while (dbg_done !== 1'b1 && n < 5000);
    dbg_req <= 1'b0;
    chk(n, exp, "debug stall width");
    repeat (2) @(negedge I_CLK);
    chk(stall, 1'b0, "debug ran once");
    rd(REG_STATUS, 32'h4);
  endtask
  task automatic t_ferr(input logic e, input logic s);
    reset();
    vm_en <= e;
    vm_rst <= s;
    apb(1'b1, REG_PSC, 32'h1);
    keys();
    op(0);
    chk(ferr, 1'b1, "flash error");
    vm_en <= 1'b1;
    vm_rst <= 1'b1;
    reset();
  endtask
  initial begin
    reset();
    t_basic();
    t_write_erase();
    t_dead(8'h5A);
    t_dead(KEY_SECOND);
    t_debug(DBG_WRITE, WC + 1);
    t_debug(DBG_ERASE, EC + 1);
    t_ferr(1'b0, 1'b1);
    t_ferr(1'b1, 1'b0);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge I_CLK);
    err_total++;
    print_verdict();
  end
endmodule
